//--- shared/supervisor_pkg.sv
/*
 Constants, register map and state encoding of the supervisory reset block.
 Assumes a single free-running 125 MHz clock; all timer figures derive from it.
*/
package supervisor_pkg;

   // Clock rate
   localparam longint CLOCK_MHZ = 125;
   localparam longint CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;

   // Reset hold period options, least durations in microseconds
   localparam longint HOLD_MIN_US_0 = 1000;
   localparam longint HOLD_MIN_US_1 = 20000;
   localparam longint HOLD_MIN_US_2 = 140000;
   localparam longint HOLD_MIN_US_3 = 1120000;
   localparam longint HOLD_CYCLES_0 = HOLD_MIN_US_0 * CLOCK_MHZ;
   localparam longint HOLD_CYCLES_1 = HOLD_MIN_US_1 * CLOCK_MHZ;
   localparam longint HOLD_CYCLES_2 = HOLD_MIN_US_2 * CLOCK_MHZ;
   localparam longint HOLD_CYCLES_3 = HOLD_MIN_US_3 * CLOCK_MHZ;

   // Watchdog timeout options, typical periods in microseconds
   localparam longint WD_TYP_US_0 = 6300;
   localparam longint WD_TYP_US_1 = 102000;
   localparam longint WD_TYP_US_2 = 1600000;
   localparam longint WD_TYP_US_3 = 25600000;
   localparam longint WD_CYCLES_0 = WD_TYP_US_0 * CLOCK_MHZ;
   localparam longint WD_CYCLES_1 = WD_TYP_US_1 * CLOCK_MHZ;
   localparam longint WD_CYCLES_2 = WD_TYP_US_2 * CLOCK_MHZ;
   localparam longint WD_CYCLES_3 = WD_TYP_US_3 * CLOCK_MHZ;

   // Manual reset glitch rejection, least low time that counts as a press
   localparam longint GLITCH_TIME_NS = 100;
   localparam logic [31:0] GLITCH_CYCLES =
      32'((GLITCH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   // Release must stay high this long before the press is over
   localparam longint DEBOUNCE_TIME_US = 10000;
   localparam longint DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLOCK_MHZ;
   // Shortest strobe pulse to catch; one clock already resolves it
   localparam longint STROBE_MIN_NS = 50;
   localparam logic [31:0] STROBE_FILTER_CYCLES = 32'h1;

   localparam int COUNT_W = 32;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SEL_W = 2;

   // Register map
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
   localparam int CTRL_HOLD_LSB = 0;
   localparam int CTRL_WD_LSB = 2;
   localparam int CTRL_WDEN_BIT = 4;
   localparam int ST_RESET_BIT = 0;
   localparam int ST_UV_BIT = 1;
   localparam int ST_MR_BIT = 2;
   localparam int ST_FLOAT_BIT = 3;
   localparam int ST_TRIP_BIT = 4;
   localparam logic [SEL_W-1:0] HOLD_SEL_RESET = 2'h2;
   localparam logic [SEL_W-1:0] WD_SEL_RESET = 2'h2;
   localparam logic WDEN_RESET = 1'b1;

   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b001,
      ST_HOLD = 3'b010,
      ST_RUN = 3'b100
   } state_t;

endpackage : supervisor_pkg

//--- src/level_filter.sv
/*
 Two-stage synchroniser followed by a stability filter with separate
 qualification times for the falling and the rising direction.
 Assumes the raw input may be fully asynchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module level_filter #(
   parameter logic [31:0] LOW_CYCLES = 32'h1,
   parameter logic [31:0] HIGH_CYCLES = 32'h1,
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic raw,
   output logic level
);
   logic sync1;
   logic sync2;
   logic [31:0] count;
   logic [31:0] target;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1 <= RESET_LEVEL;
         sync2 <= RESET_LEVEL;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   assign target = level ? LOW_CYCLES : HIGH_CYCLES;

   // A change is taken only after it has held for the full target time
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         level <= RESET_LEVEL;
         count <= 32'h0;
      end else if (sync2 == level) begin
         count <= 32'h0;
      end else if (count >= target - 32'h1) begin
         level <= sync2;
         count <= 32'h0;
      end else begin
         count <= count + 32'h1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_low_qualified: assert property (
      $fell(level) |-> ($past(count) == LOW_CYCLES - 32'h1) && !$past(sync2))
      else $error("filtered level fell before the low time elapsed");
   a_high_qualified: assert property (
      $rose(level) |-> ($past(count) == HIGH_CYCLES - 32'h1) && $past(sync2))
      else $error("filtered level rose before the high time elapsed");

endmodule : level_filter
`default_nettype wire

//--- src/supervisory_reset_watchdog.sv
/*
 Supervisory reset generator: undervoltage, manual reset and watchdog
 causes, hold period, and a small register port for selection and status.
 Assumes undervoltage and the floating indication come synchronous to clock
 from the analog front end; manual reset and strobe may be asynchronous.
*/
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module supervisory_reset_watchdog #(
   parameter bit HAS_WATCHDOG = 1'b1,
   parameter bit HAS_MANUAL_RESET = 1'b1,
   parameter bit HAS_COMPLEMENT = 1'b1,
   parameter logic [31:0] HOLD_CYCLES_0 = 32'(supervisor_pkg::HOLD_CYCLES_0),
   parameter logic [31:0] HOLD_CYCLES_1 = 32'(supervisor_pkg::HOLD_CYCLES_1),
   parameter logic [31:0] HOLD_CYCLES_2 = 32'(supervisor_pkg::HOLD_CYCLES_2),
   parameter logic [31:0] HOLD_CYCLES_3 = 32'(supervisor_pkg::HOLD_CYCLES_3),
   parameter logic [31:0] WD_CYCLES_0 = 32'(supervisor_pkg::WD_CYCLES_0),
   parameter logic [31:0] WD_CYCLES_1 = 32'(supervisor_pkg::WD_CYCLES_1),
   parameter logic [31:0] WD_CYCLES_2 = 32'(supervisor_pkg::WD_CYCLES_2),
   parameter logic [31:0] WD_CYCLES_3 = 32'(supervisor_pkg::WD_CYCLES_3),
   parameter logic [31:0] DEBOUNCE_CYCLES = 32'(supervisor_pkg::DEBOUNCE_CYCLES)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic undervoltage,
   input wire logic manual_reset_n,
   input wire logic watchdog_strobe,
   input wire logic watchdog_strobe_floating,
   input wire logic [supervisor_pkg::ADDR_W-1:0] addr,
   input wire logic [supervisor_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [supervisor_pkg::DATA_W-1:0] rdata,
   output logic reset_n,
   output logic reset_out
);
   import supervisor_pkg::*;

   state_t state;
   state_t next_state;

   logic mr_level;
   logic strobe_level;
   logic strobe_prev;
   logic mr_low;
   logic level_cause;
   logic strobe_edge;
   logic wd_armed;
   logic wd_terminal;
   logic wd_expire;
   logic hold_done;
   logic wd_tripped;

   logic [COUNT_W-1:0] wd_count;
   logic [COUNT_W-1:0] hold_count;
   logic [COUNT_W-1:0] hold_cycles;
   logic [COUNT_W-1:0] timeout_cycles;

   logic [SEL_W-1:0] hold_select;
   logic [SEL_W-1:0] timeout_select;
   logic wd_enable;

   logic [DATA_W-1:0] ctrl_image;
   logic [DATA_W-1:0] status_image;

   // Input conditioning
   // Manual reset: short lows rejected, release must settle before it counts
   level_filter #(
      .LOW_CYCLES(GLITCH_CYCLES),
      .HIGH_CYCLES(DEBOUNCE_CYCLES),
      .RESET_LEVEL(1'b1)
   ) mr_filter (
      .clock(clock),
      .rst(rst),
      .raw(manual_reset_n),
      .level(mr_level)
   );

   // Strobe is only synchronised; no filter, so narrow pulses survive
   level_filter #(
      .LOW_CYCLES(STROBE_FILTER_CYCLES),
      .HIGH_CYCLES(STROBE_FILTER_CYCLES),
      .RESET_LEVEL(1'b0)
   ) strobe_filter (
      .clock(clock),
      .rst(rst),
      .raw(watchdog_strobe),
      .level(strobe_level)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strobe_prev <= 1'b0;
      end else begin
         strobe_prev <= strobe_level;
      end
   end

   assign mr_low = HAS_MANUAL_RESET && !mr_level;
   assign level_cause = undervoltage || mr_low;
   assign strobe_edge = strobe_level ^ strobe_prev;

   // Period selection
   always_comb begin
      case (hold_select)
         2'h0: hold_cycles = HOLD_CYCLES_0;
         2'h1: hold_cycles = HOLD_CYCLES_1;
         2'h2: hold_cycles = HOLD_CYCLES_2;
         default: hold_cycles = HOLD_CYCLES_3;
      endcase
   end

   always_comb begin
      case (timeout_select)
         2'h0: timeout_cycles = WD_CYCLES_0;
         2'h1: timeout_cycles = WD_CYCLES_1;
         2'h2: timeout_cycles = WD_CYCLES_2;
         default: timeout_cycles = WD_CYCLES_3;
      endcase
   end

   // Watchdog timer
   // Compare with >= so that shortening the selection mid-count still ends
   assign wd_terminal = wd_count >= timeout_cycles - 32'h1;
   // Floating strobe keeps the counter running but cuts it off from reset
   assign wd_armed = HAS_WATCHDOG && wd_enable && !watchdog_strobe_floating;
   assign wd_expire = (state == ST_RUN) && wd_terminal && !strobe_edge && wd_armed;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wd_count <= '0;
      end else if (state != ST_RUN || next_state != ST_RUN) begin
         // Leaving run clears at once, so the first reset cycle sees zero
         wd_count <= '0;
      end else if (strobe_edge || wd_terminal) begin
         wd_count <= '0;
      end else begin
         wd_count <= wd_count + 32'h1;
      end
   end

   // Hold timer
   assign hold_done = hold_count >= hold_cycles - 32'h1;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hold_count <= '0;
      end else if (state != ST_HOLD || hold_done) begin
         hold_count <= '0;
      end else begin
         hold_count <= hold_count + 32'h1;
      end
   end

   // Reset sequencer
   // Level causes win over everything; expiry is an event that goes
   // straight into the hold period because the cause is already over.
   always_comb begin
      next_state = state;
      case (state)
         ST_ACTIVE: begin
            if (!level_cause) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (level_cause) begin
               next_state = ST_ACTIVE;
            end else if (hold_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (level_cause) begin
               next_state = ST_ACTIVE;
            end else if (wd_expire) begin
               next_state = ST_HOLD;
            end
         end
         default: begin
            next_state = ST_ACTIVE;
         end
      endcase
   end

   // Power-up enters the hold period so the processor gets a full reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reset_n <= 1'b0;
         reset_out <= HAS_COMPLEMENT;
      end else begin
         reset_n <= (next_state == ST_RUN);
         reset_out <= HAS_COMPLEMENT && (next_state != ST_RUN);
      end
   end

   // Register port
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hold_select <= HOLD_SEL_RESET;
         timeout_select <= WD_SEL_RESET;
         wd_enable <= WDEN_RESET;
      end else if (wr && addr == CTRL_ADDR) begin
         hold_select <= wdata[CTRL_HOLD_LSB +: SEL_W];
         timeout_select <= wdata[CTRL_WD_LSB +: SEL_W];
         wd_enable <= wdata[CTRL_WDEN_BIT];
      end
   end

   // Sticky expiry flag; a new expiry beats a clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wd_tripped <= 1'b0;
      end else if (wd_expire) begin
         wd_tripped <= 1'b1;
      end else if (wr && addr == STATUS_ADDR && wdata[ST_TRIP_BIT]) begin
         wd_tripped <= 1'b0;
      end
   end

   always_comb begin
      ctrl_image = '0;
      ctrl_image[CTRL_HOLD_LSB +: SEL_W] = hold_select;
      ctrl_image[CTRL_WD_LSB +: SEL_W] = timeout_select;
      ctrl_image[CTRL_WDEN_BIT] = wd_enable;
   end

   always_comb begin
      status_image = '0;
      status_image[ST_RESET_BIT] = !reset_n;
      status_image[ST_UV_BIT] = undervoltage;
      status_image[ST_MR_BIT] = mr_low;
      status_image[ST_FLOAT_BIT] = watchdog_strobe_floating;
      status_image[ST_TRIP_BIT] = wd_tripped;
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (!rd) begin
         rdata <= '0;
      end else if (addr == CTRL_ADDR) begin
         rdata <= ctrl_image;
      end else if (addr == STATUS_ADDR) begin
         rdata <= status_image;
      end else begin
         rdata <= '0;
      end
   end

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_cause_ends;
      level_cause ##1 !level_cause;
   endsequence

   sequence s_hold_entered;
      (state == ST_HOLD) && !reset_n;
   endsequence

   a_cause_asserts: assert property (
      level_cause |=> !reset_n)
      else $error("reset not asserted while a level cause is present");

   a_hold_starts: assert property (
      s_cause_ends |=> s_hold_entered)
      else $error("hold period did not start when the cause ended");

   a_hold_full: assert property (
      $rose(reset_n) |-> $past(state == ST_HOLD)
         && ($past(hold_count) >= $past(hold_cycles) - 32'h1))
      else $error("reset released before the hold period elapsed");

   a_manual_low: assert property (
      (HAS_MANUAL_RESET && !mr_level) |=> !reset_n ##1 !reset_n)
      else $error("manual low did not keep reset asserted");

   a_strobe_clears: assert property (
      (strobe_edge && state == ST_RUN) |=> wd_count == '0)
      else $error("strobe edge did not clear the watchdog");

   a_expiry_resets: assert property (
      wd_expire |-> (wd_count >= timeout_cycles - 32'h1)
         ##1 s_hold_entered)
      else $error("expiry did not start a reset at the selected timeout");

   a_cause_clears_wd: assert property (
      level_cause |-> ##2 wd_count == '0)
      else $error("watchdog not cleared by undervoltage or manual reset");

   a_wd_held: assert property (
      !reset_n |-> wd_count == '0)
      else $error("watchdog counted while reset was asserted");

   a_float_no_trip: assert property (
      watchdog_strobe_floating |-> !wd_expire)
      else $error("floating strobe let the watchdog assert reset");

   a_outputs_match: assert property (
      reset_out == (HAS_COMPLEMENT && !reset_n))
      else $error("complement reset output disagrees with reset_n");

   a_run_counts: assert property (
      (state == ST_RUN && next_state == ST_RUN && !strobe_edge && !wd_terminal)
         |=> wd_count == $past(wd_count) + 32'h1)
      else $error("watchdog counter did not advance while running");

   a_hold_counts: assert property (
      (state == ST_HOLD && next_state == ST_HOLD && !hold_done)
         |=> hold_count == $past(hold_count) + 32'h1)
      else $error("hold counter did not advance during the hold period");

   a_trip_sticky: assert property (
      wd_expire |=> wd_tripped)
      else $error("watchdog expiry did not set the tripped flag");

endmodule : supervisory_reset_watchdog
`default_nettype wire

//--- verification/processor_model.sv
/*
 Behavioural processor on the far side of the supervisor: receives reset_n
 and services the watchdog strobe.
 Assumes mode 0 strobes, 1 is stuck in a subroutine, 2 releases the pin.
*/
`timescale 1ns/10ps
`default_nettype none
module processor_model #(
   parameter int PERIOD = 40,
   parameter int PULSE = 7
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [1:0] mode,
   output logic watchdog_strobe,
   output logic watchdog_strobe_floating
);
   int phase = 0;
   logic last_driven = 1'b0;
   logic pulse_now;

   initial begin
      watchdog_strobe = 1'b0;
      watchdog_strobe_floating = 1'b0;
   end

   // Service loop restarts when the processor leaves reset
   always @(posedge clock) begin
      if (reset_n !== 1'b1) begin
         phase <= 0;
      end else if (phase == PERIOD - 1) begin
         phase <= 0;
      end else begin
         phase <= phase + 1;
      end
   end

   // Short high pulse at the end of each loop; stuck mode leaves it low
   assign pulse_now = (mode == 2'h0) && (reset_n === 1'b1) && (phase >= PERIOD - PULSE);

   always @(posedge clock) begin
      if (mode == 2'h2) begin
         // Released pin: simulator must not settle it to the last value
         watchdog_strobe <= ~last_driven;
         watchdog_strobe_floating <= 1'b1;
      end else begin
         last_driven <= pulse_now;
         watchdog_strobe <= pulse_now;
         watchdog_strobe_floating <= 1'b0;
      end
   end
endmodule : processor_model
`default_nettype wire

//--- verification/supervisory_reset_watchdog_bench.sv
/*
 Self-checking bench: power-up hold, hold and timeout options, watchdog
 service, floating strobe, registers and manual reset.
 Assumes shortened timer parameters and processor_model on the strobe side.
*/
`timescale 1ns/10ps
`default_nettype none
module supervisory_reset_watchdog_bench;
   import supervisor_pkg::*;
   localparam int HOLD [4] = '{20, 30, 40, 50};
   localparam int WD [4] = '{60, 80, 100, 120};
   localparam int DEB = 8;
   // Sync stages and state hand-over add a few cycles to each count
   localparam int SLACK = 4;

   logic clock, rst, undervoltage, manual_reset_n, wr, rd, reset_n, reset_out;
   logic watchdog_strobe, watchdog_strobe_floating;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic [1:0] mode;
   int failures = 0;
   int n_compared = 0;
   int falls = 0;
   int n, f0;

   supervisory_reset_watchdog #(
      .HOLD_CYCLES_0(32'(HOLD[0])), .HOLD_CYCLES_1(32'(HOLD[1])),
      .HOLD_CYCLES_2(32'(HOLD[2])), .HOLD_CYCLES_3(32'(HOLD[3])),
      .WD_CYCLES_0(32'(WD[0])), .WD_CYCLES_1(32'(WD[1])),
      .WD_CYCLES_2(32'(WD[2])), .WD_CYCLES_3(32'(WD[3])),
      .DEBOUNCE_CYCLES(32'(DEB))
   ) i_dut (
      .clock(clock), .rst(rst), .undervoltage(undervoltage),
      .manual_reset_n(manual_reset_n), .watchdog_strobe(watchdog_strobe),
      .watchdog_strobe_floating(watchdog_strobe_floating), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .reset_n(reset_n),
      .reset_out(reset_out)
   );

   processor_model i_cpu (
      .clock(clock), .reset_n(reset_n), .mode(mode),
      .watchdog_strobe(watchdog_strobe),
      .watchdog_strobe_floating(watchdog_strobe_floating)
   );

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(negedge reset_n) falls <= falls + 1;

   task finish_test;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task check_range(input string name, input int lo, input int hi, input int got);
      n_compared++;
      if (got < lo || got > hi) begin
         failures++;
         $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask : check_range

   task cyc(input int k);
      repeat (k) @(posedge clock);
   endtask : cyc

   task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   task rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg

   // Bounded count of cycles until reset_n reaches the given level
   task span(input logic lvl, output int k);
      k = 0;
      while (reset_n !== lvl && k < 5000) begin
         @(posedge clock);
         #1;
         k++;
      end
   endtask : span

   task uv_pulse(input int len);
      @(posedge clock);
      undervoltage <= 1'b1;
      cyc(len);
      undervoltage <= 1'b0;
   endtask : uv_pulse

   initial begin
      #200000;
      failures++;
      finish_test;
   end

   initial begin
      rst = 1'b1;
      undervoltage = 1'b0;
      manual_reset_n = 1'b1;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      mode = 2'h0;
      cyc(6);
      rst <= 1'b0;
      #1 check("reset_n", 32'h0, 32'(reset_n));
      check("reset_out", 32'h1, 32'(reset_out));
      span(1'b1, n);
      check_range("powerup hold", HOLD[2], HOLD[2] + SLACK, n);
      check("reset_out", 32'h0, 32'(reset_out));
      rd_reg(CTRL_ADDR, d);
      check("ctrl reset", 32'h1a, d);
      wr_reg(8'h08, 32'hffffffff);
      rd_reg(8'h08, d);
      check("unmapped", 32'h0, d);
      rd_reg(CTRL_ADDR, d);
      check("ctrl kept", 32'h1a, d);
      for (int s = 0; s < 4; s++) begin
         wr_reg(CTRL_ADDR, 32'h10 | 32'(s));
         uv_pulse(4);
         span(1'b1, n);
         check_range("uv hold", HOLD[s], HOLD[s] + SLACK, n);
      end
      f0 = falls;
      cyc(400);
      check("serviced falls", 32'(f0), 32'(falls));
      @(posedge clock);
      mode <= 2'h1;
      uv_pulse(2);
      for (int w = 0; w < 4; w++) begin
         wr_reg(CTRL_ADDR, 32'h10 | 32'(w << 2));
         span(1'b1, n);
         span(1'b0, n);
         check_range("wd timeout", WD[w], WD[w] + SLACK, n);
      end
      rd_reg(STATUS_ADDR, d);
      check("trip set", 32'h10, d & 32'h10);
      wr_reg(STATUS_ADDR, 32'h10);
      rd_reg(STATUS_ADDR, d);
      check("trip clear", 32'h0, d & 32'h10);
      wr_reg(CTRL_ADDR, 32'h10);
      span(1'b1, n);
      cyc(30);
      uv_pulse(2);
      span(1'b1, n);
      span(1'b0, n);
      check_range("wd after uv", WD[0], WD[0] + SLACK, n);
      // Watchdog switched off while the processor is stuck: no expiry
      wr_reg(CTRL_ADDR, 32'h0);
      span(1'b1, n);
      f0 = falls;
      cyc(150);
      check("disabled falls", 32'(f0), 32'(falls));
      @(posedge clock);
      mode <= 2'h2;
      cyc(2);
      wr_reg(CTRL_ADDR, 32'h10);
      f0 = falls;
      cyc(300);
      check("floating falls", 32'(f0), 32'(falls));
      rd_reg(STATUS_ADDR, d);
      check("status float", 32'h8, d & 32'h9);
      @(posedge clock);
      mode <= 2'h0;
      cyc(50);
      f0 = falls;
      @(posedge clock);
      manual_reset_n <= 1'b0;
      cyc(10);
      manual_reset_n <= 1'b1;
      cyc(40);
      check("glitch falls", 32'(f0), 32'(falls));
      manual_reset_n <= 1'b0;
      cyc(30);
      #1 check("manual low", 32'h0, 32'(reset_n));
      rd_reg(STATUS_ADDR, d);
      check("status manual", 32'h5, d & 32'h7);
      @(posedge clock);
      manual_reset_n <= 1'b1;
      cyc(3);
      manual_reset_n <= 1'b0;
      cyc(3);
      manual_reset_n <= 1'b1;
      span(1'b1, n);
      check_range("manual hold", DEB + HOLD[0], DEB + HOLD[0] + 2 * SLACK, n);
      check("press falls", 32'(f0 + 1), 32'(falls));
      finish_test;
   end
endmodule : supervisory_reset_watchdog_bench
`default_nettype wire
